// [verilog/lra_drive_brake_tracking_cfg.sv]
// Resonant burst drive engine with its configuration and result registers
// Summary of operation
// - Upper nibble gain scales brake under boost
// - Lower nibble gain scales brake without boost
// - Tracking enable bit seven, resets to one
// - First phase level, seven bits, reset 7F
// - Second phase level, reset 50, bit seven unused
// - Battery mode without boost: reference times level over battery voltage, rail saturated
// - Otherwise amplitude is rail times level/128
// - First phase lasts programmed half cycles
// - Second phase lasts programmed half cycles
// - Brake lasts programmed half cycles
// - Tracking margin widens half-cycle acceptance window
// - Probe period readable as two bytes
// - Running period readable as two bytes
// - Fixed width times half cycle without tracking
// - Probe enable routes idle measurement
`timescale 1ns/10ps
`include "lra_drive_defs.svh"

module lra_drive_brake_tracking_cfg #(
  parameter int TICK_DIV = `LRA_TICK_DIV
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Drive control and supply state
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic boost_mode_in,
  input wire logic battery_comp_in,
  input wire logic [7:0] battery_ref_in,
  input wire logic [7:0] battery_volt_in,
  input wire logic zero_cross_in,
  // Bridge control
  output logic bridge_en_out,
  output logic bridge_pol_out,
  output logic [7:0] amplitude_out,
  output logic busy_out
);

  logic tick;
  logic probe_en_r;
  logic [7:0] fixed_width_r;
  logic [3:0] boosted_brake_gain_r;
  logic [3:0] direct_brake_gain_r;
  logic track_en_r;
  logic [6:0] first_phase_level_r;
  logic [6:0] second_phase_level_r;
  logic [7:0] first_phase_halfcycles_r;
  logic [7:0] second_phase_halfcycles_r;
  logic [7:0] brake_halfcycles_r;
  logic [4:0] margin_r;
  logic [15:0] probe_period_r;
  logic [15:0] run_period_r;
  lra_drive_pkg::drive_state_t state_r;
  logic [15:0] hc_ticks_r;
  logic [7:0] hc_cnt_r;
  logic pol_r;
  logic [15:0] per_cnt_r;
  logic zc_odd_r;
  logic [15:0] fixed_lim;
  logic [15:0] exp_half;
  logic [15:0] margin_ticks;
  logic track_ok;
  logic hc_end;
  logic [7:0] phase_len;
  logic [7:0] rd_nxt;
  logic [7:0] amp_nxt;
  logic [7:0] brake_amp;
  logic [3:0] brake_gain;

  lra_tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .tick_out(tick)
  );

  // Fraction of the bridge rail in 1/128 steps
  function automatic logic [7:0] rail_code(input logic [6:0] lvl);
    logic [15:0] prod;
    logic [15:0] quot;
    prod = {8'h00, battery_ref_in} * {9'h000, lvl};
    // A dead battery reading saturates rather than dividing by zero
    quot = (battery_volt_in == 8'h00) ? 16'hFFFF : prod / {8'h00, battery_volt_in};
    if (battery_comp_in && !boost_mode_in) begin
      rail_code = (quot > {8'h00, `LRA_FULL_RAIL}) ? `LRA_FULL_RAIL : quot[7:0];
    end else begin
      rail_code = {1'b0, lvl};
    end
  endfunction

  // Configuration writes
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      probe_en_r <= `LRA_RST_PROBE_EN;
      fixed_width_r <= `LRA_RST_FIXED_WIDTH;
      boosted_brake_gain_r <= `LRA_RST_BOOST_GAIN;
      direct_brake_gain_r <= `LRA_RST_DIRECT_GAIN;
      track_en_r <= `LRA_RST_TRACK_EN;
      first_phase_level_r <= `LRA_RST_LVL1;
      second_phase_level_r <= `LRA_RST_LVL2;
      first_phase_halfcycles_r <= `LRA_RST_LEN1;
      second_phase_halfcycles_r <= `LRA_RST_LEN2;
      brake_halfcycles_r <= `LRA_RST_BRK_LEN;
      margin_r <= `LRA_RST_MARGIN;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `LRA_OFS_PROBE_CFG: probe_en_r <= reg_wdata_in[`LRA_PROBE_EN_BIT];
        `LRA_OFS_FIXED_WIDTH: fixed_width_r <= reg_wdata_in;
        `LRA_OFS_BRAKE_GAIN: begin
          boosted_brake_gain_r <= reg_wdata_in[7:4];
          direct_brake_gain_r <= reg_wdata_in[3:0];
        end
        `LRA_OFS_TRACK_LVL1: begin
          track_en_r <= reg_wdata_in[`LRA_TRACK_EN_BIT];
          first_phase_level_r <= reg_wdata_in[6:0];
        end
        // Bit 7 is dropped so it cannot reach the drive level
        `LRA_OFS_LVL2: second_phase_level_r <= reg_wdata_in[6:0];
        `LRA_OFS_LEN1: first_phase_halfcycles_r <= reg_wdata_in;
        `LRA_OFS_LEN2: second_phase_halfcycles_r <= reg_wdata_in;
        `LRA_OFS_BRK_LEN: brake_halfcycles_r <= reg_wdata_in;
        `LRA_OFS_MARGIN: margin_r <= reg_wdata_in[4:0];
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_nxt = 8'h00;
    case (reg_addr_in)
      `LRA_OFS_PROBE_CFG: rd_nxt[`LRA_PROBE_EN_BIT] = probe_en_r;
      `LRA_OFS_FIXED_WIDTH: rd_nxt = fixed_width_r;
      `LRA_OFS_BRAKE_GAIN: rd_nxt = {boosted_brake_gain_r, direct_brake_gain_r};
      `LRA_OFS_TRACK_LVL1: rd_nxt = {track_en_r, first_phase_level_r};
      `LRA_OFS_LVL2: rd_nxt = {1'b0, second_phase_level_r};
      `LRA_OFS_LEN1: rd_nxt = first_phase_halfcycles_r;
      `LRA_OFS_LEN2: rd_nxt = second_phase_halfcycles_r;
      `LRA_OFS_BRK_LEN: rd_nxt = brake_halfcycles_r;
      `LRA_OFS_MARGIN: rd_nxt = {3'b000, margin_r};
      `LRA_OFS_PROBE_HI: rd_nxt = probe_period_r[15:8];
      `LRA_OFS_PROBE_LO: rd_nxt = probe_period_r[7:0];
      `LRA_OFS_RUN_HI: rd_nxt = run_period_r[15:8];
      `LRA_OFS_RUN_LO: rd_nxt = run_period_r[7:0];
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_nxt;
    end
  end

  // Resonance period measurement, one count per 1/384000 s, over two crossings
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      per_cnt_r <= 16'h0000;
      zc_odd_r <= 1'b0;
      probe_period_r <= `LRA_RST_PERIOD;
      run_period_r <= `LRA_RST_PERIOD;
    end else if (zero_cross_in) begin
      zc_odd_r <= !zc_odd_r;
      if (zc_odd_r) begin
        per_cnt_r <= 16'h0000;
        if (state_r != lra_drive_pkg::st_idle) begin
          run_period_r <= per_cnt_r;
        end else if (probe_en_r) begin
          probe_period_r <= per_cnt_r;
        end
      end else if (tick && per_cnt_r != 16'hFFFF) begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
    end else if (tick && per_cnt_r != 16'hFFFF) begin
      // Saturate so a stalled actuator reads as the slowest period
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  // Half-cycle timing
  always_comb begin
    fixed_lim = 16'({8'h00, fixed_width_r} * `LRA_WIDTH_SCALE);
    exp_half = {1'b0, run_period_r[15:1]};
    margin_ticks = 16'(({27'h0, margin_r} * `LRA_TICK_HZ) / `LRA_MARGIN_HZ);
    // Brake always times from the fixed width
    track_ok = track_en_r && (run_period_r != 16'h0000) &&
      (state_r != lra_drive_pkg::st_brake);
    if (track_ok) begin
      hc_end = (zero_cross_in && (hc_ticks_r + margin_ticks >= exp_half)) ||
        (hc_ticks_r >= exp_half + margin_ticks);
    end else begin
      // The ending tick is the last of the half cycle, so stop one count short
      hc_end = tick && (hc_ticks_r + 16'h0001 >= fixed_lim);
    end
  end

  always_comb begin
    case (state_r)
      lra_drive_pkg::st_first: phase_len = first_phase_halfcycles_r;
      lra_drive_pkg::st_second: phase_len = second_phase_halfcycles_r;
      lra_drive_pkg::st_brake: phase_len = brake_halfcycles_r;
      default: phase_len = 8'h00;
    endcase
  end

  // Phase sequencer; a zero length still runs one half cycle
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_r <= lra_drive_pkg::st_idle;
      hc_ticks_r <= 16'h0000;
      hc_cnt_r <= 8'h00;
      pol_r <= 1'b0;
    end else if (stop_in) begin
      state_r <= lra_drive_pkg::st_idle;
      hc_ticks_r <= 16'h0000;
      hc_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        lra_drive_pkg::st_idle: begin
          hc_ticks_r <= 16'h0000;
          hc_cnt_r <= 8'h00;
          if (start_in) begin
            state_r <= lra_drive_pkg::st_first;
            pol_r <= 1'b0;
          end
        end
        default: begin
          if (hc_end) begin
            hc_ticks_r <= 16'h0000;
            pol_r <= !pol_r;
            if (hc_cnt_r + 8'h01 >= phase_len) begin
              hc_cnt_r <= 8'h00;
              case (state_r)
                lra_drive_pkg::st_first: state_r <= lra_drive_pkg::st_second;
                lra_drive_pkg::st_second: state_r <= lra_drive_pkg::st_brake;
                default: state_r <= lra_drive_pkg::st_idle;
              endcase
            end else begin
              hc_cnt_r <= hc_cnt_r + 8'h01;
            end
          end else if (tick && hc_ticks_r != 16'hFFFF) begin
            hc_ticks_r <= hc_ticks_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // Brake strength: first level scaled by the gain of the active supply
  always_comb begin
    brake_gain = boost_mode_in ? boosted_brake_gain_r : direct_brake_gain_r;
    brake_amp = `LRA_FULL_RAIL;
    if ((12'(rail_code(first_phase_level_r)) * 12'(brake_gain)) <
      12'(`LRA_FULL_RAIL * `LRA_BRAKE_GAIN_UNIT)) begin
      brake_amp = 8'((12'(rail_code(first_phase_level_r)) * 12'(brake_gain)) /
        12'(`LRA_BRAKE_GAIN_UNIT));
    end
  end

  always_comb begin
    case (state_r)
      lra_drive_pkg::st_first: amp_nxt = rail_code(first_phase_level_r);
      lra_drive_pkg::st_second: amp_nxt = rail_code(second_phase_level_r);
      lra_drive_pkg::st_brake: amp_nxt = brake_amp;
      default: amp_nxt = 8'h00;
    endcase
  end

  // Bridge outputs; brake drives against the motion
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      bridge_en_out <= 1'b0;
      bridge_pol_out <= 1'b0;
      amplitude_out <= 8'h00;
      busy_out <= 1'b0;
    end else begin
      bridge_en_out <= (state_r != lra_drive_pkg::st_idle);
      bridge_pol_out <= pol_r ^ (state_r == lra_drive_pkg::st_brake);
      amplitude_out <= amp_nxt;
      busy_out <= (state_r != lra_drive_pkg::st_idle);
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_track_wr;
    reg_wr_in && reg_addr_in == `LRA_OFS_TRACK_LVL1 |=>
      track_en_r == $past(reg_wdata_in[7]) && first_phase_level_r == $past(reg_wdata_in[6:0]);
  endproperty
  a_track_wr: assert property (p_track_wr) else $error("tracking byte not stored");

  property p_lvl2_rsv;
    reg_rd_in && reg_addr_in == `LRA_OFS_LVL2 |=> reg_rdata_out[7] == 1'b0;
  endproperty
  a_lvl2_rsv: assert property (p_lvl2_rsv) else $error("reserved bit reads one");

  property p_margin_rsv;
    reg_rd_in && reg_addr_in == `LRA_OFS_MARGIN |=> reg_rdata_out[7:5] == 3'b000;
  endproperty
  a_margin_rsv: assert property (p_margin_rsv) else $error("margin top bits nonzero");

  property p_probe_rd;
    reg_rd_in && reg_addr_in == `LRA_OFS_PROBE_HI |=>
      reg_rdata_out == $past(probe_period_r[15:8]);
  endproperty
  a_probe_rd: assert property (p_probe_rd) else $error("probe high byte wrong");

  property p_run_capture;
    zero_cross_in && zc_odd_r && state_r != lra_drive_pkg::st_idle |=>
      run_period_r == $past(per_cnt_r) && per_cnt_r == 16'h0000;
  endproperty
  a_run_capture: assert property (p_run_capture) else $error("running period lost");

  property p_probe_gate;
    zero_cross_in && zc_odd_r && state_r == lra_drive_pkg::st_idle && !probe_en_r |=>
      $stable(probe_period_r);
  endproperty
  a_probe_gate: assert property (p_probe_gate) else $error("probe disabled but updated");

  property p_order;
    state_r == lra_drive_pkg::st_first && !stop_in |=>
      state_r == lra_drive_pkg::st_first || state_r == lra_drive_pkg::st_second;
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");

  property p_brake_end;
    state_r == lra_drive_pkg::st_brake && hc_end && !stop_in &&
      hc_cnt_r + 8'h01 >= brake_halfcycles_r |=> state_r == lra_drive_pkg::st_idle;
  endproperty
  a_brake_end: assert property (p_brake_end) else $error("brake did not end");

  property p_len1;
    state_r == lra_drive_pkg::st_first && hc_end && !stop_in &&
      hc_cnt_r + 8'h01 < first_phase_halfcycles_r |=> state_r == lra_drive_pkg::st_first;
  endproperty
  a_len1: assert property (p_len1) else $error("first phase left early");

  property p_fixed;
    !track_en_r && state_r != lra_drive_pkg::st_idle && tick &&
      hc_ticks_r + 16'h0001 < fixed_lim |-> !hc_end;
  endproperty
  a_fixed: assert property (p_fixed) else $error("half cycle shorter than width");

  property p_sat;
    battery_comp_in && !boost_mode_in |-> rail_code(first_phase_level_r) <= `LRA_FULL_RAIL;
  endproperty
  a_sat: assert property (p_sat) else $error("amplitude above rail");

  property p_direct;
    !battery_comp_in && state_r == lra_drive_pkg::st_second |=>
      amplitude_out == {1'b0, $past(second_phase_level_r)};
  endproperty
  a_direct: assert property (p_direct) else $error("direct amplitude wrong");

  property p_brake_gain;
    state_r == lra_drive_pkg::st_brake && boost_mode_in && boosted_brake_gain_r == 4'h0 |=>
      amplitude_out == 8'h00;
  endproperty
  a_brake_gain: assert property (p_brake_gain) else $error("boost brake gain ignored");

endmodule // lra_drive_brake_tracking_cfg

// [verilog/lra_drive_defs.svh]
// Offsets, field positions, reset values and timing counts of the resonant drive block
`ifndef LRA_DRIVE_DEFS_SVH
`define LRA_DRIVE_DEFS_SVH

// Register offsets
`define LRA_OFS_PROBE_CFG 8'h18
`define LRA_OFS_FIXED_WIDTH 8'h1A
`define LRA_OFS_BRAKE_GAIN 8'h1C
`define LRA_OFS_TRACK_LVL1 8'h1D
`define LRA_OFS_LVL2 8'h1E
`define LRA_OFS_LEN1 8'h1F
`define LRA_OFS_LEN2 8'h20
`define LRA_OFS_BRK_LEN 8'h21
`define LRA_OFS_MARGIN 8'h22
`define LRA_OFS_PROBE_HI 8'h25
`define LRA_OFS_PROBE_LO 8'h26
`define LRA_OFS_RUN_HI 8'h27
`define LRA_OFS_RUN_LO 8'h28

// Field positions
`define LRA_PROBE_EN_BIT 5
`define LRA_TRACK_EN_BIT 7

// Reset values
`define LRA_RST_PROBE_EN 1'b0
`define LRA_RST_FIXED_WIDTH 8'h6A
`define LRA_RST_BOOST_GAIN 4'h5
`define LRA_RST_DIRECT_GAIN 4'h8
`define LRA_RST_TRACK_EN 1'b1
`define LRA_RST_LVL1 7'h7F
`define LRA_RST_LVL2 7'h50
`define LRA_RST_LEN1 8'h04
`define LRA_RST_LEN2 8'h06
`define LRA_RST_BRK_LEN 8'h08
`define LRA_RST_MARGIN 5'h0C
`define LRA_RST_PERIOD 16'h0000

// Amplitude scaling: full bridge rail is 128/128
`define LRA_FULL_RAIL 8'h80
`define LRA_BRAKE_GAIN_UNIT 8

// Timing
`define LRA_CLK_HZ 25000000
`define LRA_TICK_HZ 384000
`define LRA_WIDTH_HZ 48000
`define LRA_MARGIN_HZ 480000
`define LRA_TICK_DIV (`LRA_CLK_HZ / `LRA_TICK_HZ)
`define LRA_WIDTH_SCALE (`LRA_TICK_HZ / `LRA_WIDTH_HZ)

`endif

// [verilog/lra_drive_pkg.sv]
// Types shared by the resonant drive block
package lra_drive_pkg;

  typedef enum logic [1:0] {
    st_idle,
    st_first,
    st_second,
    st_brake
  } drive_state_t;

endpackage

// [verilog/lra_tick_divider.sv]
// Divides the system clock down to a one-cycle measurement tick
`timescale 1ns/10ps

module lra_tick_divider #(
  parameter int DIV = 65
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Tick
  output logic tick_out
);

  logic [15:0] cnt_r;

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      cnt_r <= 16'h0000;
      tick_out <= 1'b0;
    end else if (cnt_r == 16'(DIV - 1)) begin
      cnt_r <= 16'h0000;
      tick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick_out <= 1'b0;
    end
  end

endmodule // lra_tick_divider

// [sim/lra_actuator_model.sv]
// Behavioural resonant actuator: back-EMF zero crossings while the bridge drives it
`timescale 1ns/10ps

module lra_actuator_model #(
  parameter int HALF_CLKS = 40
) (
  // Clock
  input wire logic ref_clk_in,
  // Motion
  input wire logic run_in,
  // Back-EMF sense
  output logic zero_cross_out
);
  int cnt;

  // A resting actuator gives no crossings, so the sense line stays quiet between bursts
  always @(posedge ref_clk_in) begin
    if (!run_in) begin
      cnt <= 0;
      zero_cross_out <= 1'b0;
    end else begin
      cnt <= (cnt == HALF_CLKS - 1) ? 0 : cnt + 1;
      zero_cross_out <= (cnt == HALF_CLKS - 1);
    end
  end
endmodule // lra_actuator_model

// [sim/tb_top.sv]
// Self-checking bench for the resonant drive block
`timescale 1ns/10ps

module tb_top;
  typedef struct {logic [7:0] a; bit w; logic [7:0] d; logic [7:0] e;} row_t;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic start_in = 1'b0;
  logic stop_in = 1'b0;
  logic boost_mode_in = 1'b0;
  logic battery_comp_in = 1'b0;
  logic [7:0] battery_ref_in = 8'h80;
  logic [7:0] battery_volt_in = 8'h40;
  logic zero_cross_in;
  logic bridge_en_out, bridge_pol_out, busy_out;
  logic [7:0] amplitude_out;
  logic model_en = 1'b0;
  logic spin = 1'b0;
  logic en_q = 1'b0, pol_q = 1'b0;
  logic [7:0] amp_q = 8'h00;
  logic [7:0] seg_q [$];
  bit pseg_q [$];
  logic [7:0] rv, lo;
  int errors = 0, cmp_count = 0, cyc = 0, burst_len, i;
  row_t rows [20] = '{
    '{8'h18, 0, 8'h00, 8'h00}, '{8'h1A, 0, 8'h00, 8'h6A}, '{8'h1C, 0, 8'h00, 8'h58},
    '{8'h1D, 0, 8'h00, 8'hFF}, '{8'h1E, 0, 8'h00, 8'h50}, '{8'h1F, 0, 8'h00, 8'h04},
    '{8'h20, 0, 8'h00, 8'h06}, '{8'h21, 0, 8'h00, 8'h08}, '{8'h22, 0, 8'h00, 8'h0C},
    '{8'h25, 0, 8'h00, 8'h00}, '{8'h26, 0, 8'h00, 8'h00}, '{8'h27, 0, 8'h00, 8'h00},
    '{8'h28, 0, 8'h00, 8'h00}, '{8'h1E, 1, 8'hFF, 8'h7F}, '{8'h22, 1, 8'hFF, 8'h1F},
    '{8'h18, 1, 8'hFF, 8'h20}, '{8'h25, 1, 8'hAA, 8'h00}, '{8'h23, 1, 8'h55, 8'h00},
    '{8'h1C, 1, 8'hA3, 8'hA3}, '{8'h1F, 1, 8'h00, 8'h00}};

  lra_drive_brake_tracking_cfg #(.TICK_DIV(4)) uut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .start_in(start_in), .stop_in(stop_in),
    .boost_mode_in(boost_mode_in), .battery_comp_in(battery_comp_in),
    .battery_ref_in(battery_ref_in), .battery_volt_in(battery_volt_in),
    .zero_cross_in(zero_cross_in), .bridge_en_out(bridge_en_out),
    .bridge_pol_out(bridge_pol_out), .amplitude_out(amplitude_out), .busy_out(busy_out));

  lra_actuator_model #(.HALF_CLKS(40)) actuator (
    .ref_clk_in(ref_clk_in), .run_in((model_en & bridge_en_out) | spin),
    .zero_cross_out(zero_cross_in));

  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // Each new polarity or amplitude while driving marks one half cycle
  always @(negedge ref_clk_in) begin
    if (bridge_en_out === 1'b1 &&
        (!en_q || amplitude_out !== amp_q || bridge_pol_out !== pol_q)) begin
      seg_q.push_back(amplitude_out);
      pseg_q.push_back(bridge_pol_out);
    end
    en_q <= (bridge_en_out === 1'b1);
    amp_q <= amplitude_out;
    pol_q <= bridge_pol_out;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
      cmp_count++;
      if (seen !== exp) begin
        errors++;
        $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge ref_clk_in);
      reg_wr_in = 1'b0;
    end
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    begin
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge ref_clk_in);
      reg_rd_in = 1'b0;
      d = reg_rdata_out;
    end
  endtask

  task burst(input bit dup);
    int n;
    begin
      seg_q.delete();
      pseg_q.delete();
      @(negedge ref_clk_in);
      start_in = 1'b1;
      @(negedge ref_clk_in);
      start_in = 1'b0;
      n = 0;
      while (busy_out !== 1'b1 && n < 10) begin
        @(negedge ref_clk_in);
        n++;
      end
      burst_len = 0;
      while (busy_out === 1'b1 && burst_len < 3000) begin
        @(negedge ref_clk_in);
        start_in = dup && burst_len == 100;
        burst_len++;
      end
    end
  endtask

  task check_seq(input logic [7:0] a1, a2, a3, input int n1, n2, n3);
    int k;
    logic [7:0] e;
    begin
      chk("half_cycles", 16'(seg_q.size()), 16'(n1 + n2 + n3));
      for (k = 0; k < seg_q.size() && k < n1 + n2 + n3; k++) begin
        e = k < n1 ? a1 : (k < n1 + n2 ? a2 : a3);
        chk("phase_amp", {8'h00, seg_q[k]}, {8'h00, e});
        chk("phase_pol", {15'h0000, pseg_q[k]}, {15'h0000, 1'((k & 1) ^ (k >= n1 + n2))});
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    repeat (2) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    for (i = 0; i < 20; i++) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk("reg", {8'h00, rv}, {8'h00, rows[i].e});
    end
    // Short width keeps each untracked half cycle at 16 ticks
    wr(8'h18, 8'h00);
    wr(8'h1A, 8'h02);
    wr(8'h1C, 8'hC4);
    wr(8'h1D, 8'h30);
    wr(8'h1E, 8'h20);
    wr(8'h1F, 8'h03);
    wr(8'h20, 8'h02);
    wr(8'h21, 8'h04);
    burst(1'b1);
    check_seq(8'h30, 8'h20, 8'h18, 3, 2, 4);
    boost_mode_in = 1'b1;
    battery_comp_in = 1'b1;
    burst(1'b0);
    check_seq(8'h30, 8'h20, 8'h48, 3, 2, 4);
    // A zero boost gain must silence the brake; the direct gain stays at 4
    wr(8'h1C, 8'h04);
    burst(1'b0);
    check_seq(8'h30, 8'h20, 8'h00, 3, 2, 4);
    boost_mode_in = 1'b0;
    burst(1'b0);
    chk("batt_first", {8'h00, seg_q[0]}, 16'h0060);
    chk("batt_second", {8'h00, seg_q[3]}, 16'h0040);
    wr(8'h1F, 8'h01);
    wr(8'h1E, 8'h50);
    burst(1'b0);
    chk("batt_sat", {8'h00, seg_q[1]}, 16'h0080);
    battery_comp_in = 1'b0;
    wr(8'h1F, 8'h03);
    wr(8'h1E, 8'h20);
    wr(8'h1D, 8'hB0);
    model_en = 1'b1;
    burst(1'b0);
    burst(1'b1);
    check_seq(8'h30, 8'h20, 8'h18, 3, 2, 4);
    chk("tracked_len", 16'(burst_len < 530), 16'h0001);
    rd(8'h27, rv);
    chk("run_hi", {8'h00, rv}, 16'h0000);
    rd(8'h28, lo);
    chk("run_lo", 16'(lo >= 8'h13 && lo <= 8'h15), 16'h0001);
    wr(8'h1D, 8'h30);
    burst(1'b0);
    chk("fixed_len", 16'(burst_len > 560 && burst_len < 590), 16'h0001);
    model_en = 1'b0;
    spin = 1'b1;
    repeat (240) @(negedge ref_clk_in);
    spin = 1'b0;
    rd(8'h26, rv);
    chk("probe_off", {8'h00, rv}, 16'h0000);
    wr(8'h18, 8'h20);
    spin = 1'b1;
    repeat (240) @(negedge ref_clk_in);
    spin = 1'b0;
    rd(8'h25, rv);
    chk("probe_hi", {8'h00, rv}, 16'h0000);
    rd(8'h26, lo);
    chk("probe_lo", 16'(lo >= 8'h13 && lo <= 8'h15), 16'h0001);
    @(negedge ref_clk_in);
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    stop_in = 1'b1;
    @(negedge ref_clk_in);
    stop_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("stop_busy", {15'h0000, busy_out}, 16'h0000);
    chk("stop_en", {15'h0000, bridge_en_out}, 16'h0000);
    @(negedge ref_clk_in);
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    nrst_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk("rst_outs", {6'h00, busy_out, bridge_en_out, amplitude_out}, 16'h0000);
    nrst_in = 1'b1;
    rd(8'h1F, rv);
    chk("rst_len1", {8'h00, rv}, 16'h0004);
    report_and_stop();
  end
endmodule // tb_top
